//--- frhp_defines.svh
// timing counts, opcodes and fixed values of the flash reset/hold/protect control
`ifndef FRHP_DEFINES_SVH
`define FRHP_DEFINES_SVH

`define FRHP_CLK_PERIOD_NS   5
`define FRHP_T_RESET_NS      1000
`define FRHP_RESET_MIN_CYC   ((`FRHP_T_RESET_NS + `FRHP_CLK_PERIOD_NS - 1) / `FRHP_CLK_PERIOD_NS)
`define FRHP_T_SW_RESET_US   300
`define FRHP_SW_RESET_CYC    ((`FRHP_T_SW_RESET_US * 1000) / `FRHP_CLK_PERIOD_NS)
`define FRHP_T_WR_INHIBIT_US 1000
`define FRHP_WR_INHIBIT_CYC  ((`FRHP_T_WR_INHIBIT_US * 1000) / `FRHP_CLK_PERIOD_NS)

`define FRHP_OP_EN_RESET     8'h66
`define FRHP_OP_RESET        8'h99
`define FRHP_OP_WR_ENABLE    8'h06
`define FRHP_OP_WR_DISABLE   8'h04
`define FRHP_OP_WR_STATUS1   8'h01
`define FRHP_OP_WR_STATUS2   8'h31
`define FRHP_OP_WR_STATUS3   8'h11
`define FRHP_OP_RELEASE_DPD  8'hAB

`define FRHP_PIN_RST_LAST    3'h3

`endif

//--- frhp_pkg.sv
// types shared by the flash reset/hold/protect control
`default_nettype none
package frhp_pkg;
  // reset sequencer states, gray along por -> run -> sw reset -> run
  typedef enum logic [1:0] {
    frhp_st_por   = 2'b00,
    frhp_st_run   = 2'b01,
    frhp_st_swrst = 2'b11,
    frhp_st_hwrst = 2'b10
  } frhp_state_t;
endpackage
`default_nettype wire

//--- frhp_timer_if.sv
// start/busy handshake between the control and a delay timer
`timescale 1ns/10ps
`default_nettype none
interface frhp_timer_if;
  logic start;
  logic busy;
  modport ctrl  (output start, input busy);
  modport timer (input start, output busy);
endinterface
`default_nettype wire

//--- frhp_delay_timer.sv
// one-shot down counter: busy for CYCLES cycles after a start pulse
`timescale 1ns/10ps
`default_nettype none
module frhp_delay_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic    clk,
  input wire logic    rst_n,
  // handshake
  frhp_timer_if.timer tif
);
  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         busy_reg;

  if (CYCLES < 1) begin : g_chk
    $error("frhp_delay_timer: CYCLES must be at least 1");
  end

  // a new start reloads, so a restart stretches the interval
  assign count_next = tif.start ? W'(CYCLES) :
                      (count_reg != '0) ? count_reg - W'(1) : count_reg;
  assign tif.busy   = busy_reg;

  // busy has its own flop so the flag leaves a register, same timing as the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg  <= (count_next != '0);
    end
  end
endmodule
`default_nettype wire

//--- frhp_ctrl.sv
// flash reset, hold, reset-pin and write-protect control
`timescale 1ns/10ps
`default_nettype none
`include "frhp_defines.svh"
module frhp_ctrl
  import frhp_pkg::*;
#(
  parameter int unsigned RESET_MIN_CYC  = `FRHP_RESET_MIN_CYC,
  parameter int unsigned SW_RESET_CYC   = `FRHP_SW_RESET_CYC,
  parameter int unsigned WR_INHIBIT_CYC = `FRHP_WR_INHIBIT_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // supply monitor
  input  wire logic       por_active,
  // serial pins
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       si,
  input  wire logic       hold_rst_n,
  input  wire logic       dedicated_rst_n,
  input  wire logic       wp_n,
  // configuration bits
  input  wire logic       quad_io_enable,
  input  wire logic       pause_or_reset_sel,
  input  wire logic       protect_scheme_select,
  input  wire logic       status_lock_mode_hi,
  input  wire logic       status_lock_mode_lo,
  input  wire logic       four_byte_mode,
  // decoded instruction from the serial front end
  input  wire logic       instr_valid,
  input  wire logic [7:0] instr_code,
  input  wire logic       instr_is_prog_erase,
  input  wire logic       instr_is_ext_addr_wr,
  input  wire logic       instr_is_region_prot,
  // core status
  input  wire logic       write_in_progress,
  input  wire logic       deep_power_down,
  input  wire logic       so_drive_req,
  input  wire logic       bp_area_hit,
  input  wire logic       persistent_region_lock,
  input  wire logic       volatile_region_lock,
  // control outputs
  output logic            selected,
  output logic            standby,
  output logic            paused,
  output logic            so_oe,
  output logic            iface_reset,
  output logic            reset_busy,
  output logic            write_inhibit,
  output logic            instr_accept,
  output logic            write_enable_latch,
  output logic            status_write_ok,
  output logic            array_write_ok
);
  localparam int RW = $clog2(RESET_MIN_CYC + 1);

  if (RESET_MIN_CYC < 2 || SW_RESET_CYC < 1 || WR_INHIBIT_CYC < 1) begin : g_chk
    $error("frhp_ctrl: delay counts too small");
  end

  frhp_timer_if sw_tif ();
  frhp_timer_if wi_tif ();

  logic [1:0]    rst_sync_reg;
  logic          rst_n;
  frhp_state_t   state_reg, state_next;
  logic          cs_n_d_reg, sclk_d_reg;
  logic          armed_reg, armed_next;
  logic          paused_reg, paused_next;
  logic          clk_seen_reg, clk_seen_next;
  logic          en_rst_reg, en_rst_next;
  logic          wel_reg, wel_next;
  logic [RW-1:0] low_cnt_reg, low_cnt_next;
  logic [2:0]    jseq_reg, jseq_next;
  logic selected_reg, standby_reg, so_oe_reg, iface_reset_reg, reset_busy_reg;
  logic instr_accept_reg, status_ok_reg, array_ok_reg;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) rst_sync_reg <= 2'h0;
    else         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // pin edge detection
  wire cs_fall   = cs_n_d_reg & ~cs_n;
  wire cs_rise   = ~cs_n_d_reg & cs_n;
  wire sclk_edge = sclk ^ sclk_d_reg;

  // shared pin role; quad mode turns it into a data line
  wire pause_fn   = ~quad_io_enable & ~pause_or_reset_sel;
  wire pin_rst_fn = ~quad_io_enable & pause_or_reset_sel;
  // dedicated pin ignores the configuration bits
  wire hw_rst_low = ~dedicated_rst_n | (pin_rst_fn & ~hold_rst_n);
  wire hw_fire    = hw_rst_low && (low_cnt_reg == RW'(RESET_MIN_CYC - 1));

  // pin-only reset: expected bit alternates 0,1,0,1 with the count
  wire jbit_ok    = (si == jseq_reg[0]);
  wire jedec_fire = cs_rise & jbit_ok & ~sclk_edge & (jseq_reg == `FRHP_PIN_RST_LAST);
  wire full_fire  = hw_fire | jedec_fire;

  wire in_run  = (state_reg == frhp_st_run) & ~hw_rst_low & ~por_active;
  wire sel_now = armed_reg & ~cs_n & in_run;

  // instruction acceptance gates
  wire op_wren  = (instr_code == `FRHP_OP_WR_ENABLE);
  wire op_wrdi  = (instr_code == `FRHP_OP_WR_DISABLE);
  wire op_wrsr  = (instr_code == `FRHP_OP_WR_STATUS1) | (instr_code == `FRHP_OP_WR_STATUS2) |
                  (instr_code == `FRHP_OP_WR_STATUS3);
  wire wr_class = op_wren | op_wrsr | instr_is_prog_erase;
  wire inhibit  = wi_tif.busy;
  wire dpd_ok   = ~deep_power_down | (instr_code == `FRHP_OP_RELEASE_DPD);
  wire instr_ok = instr_valid & sel_now & ~paused_reg & dpd_ok &
                  ~(inhibit & wr_class);
  wire sw_fire  = instr_ok & (instr_code == `FRHP_OP_RESET) & en_rst_reg;

  // status register lock from lock mode bits and write-protect pin
  wire sr_locked = status_lock_mode_hi | (status_lock_mode_lo & ~wp_n);
  wire region_locked = persistent_region_lock | volatile_region_lock;
  wire area_locked   = protect_scheme_select ? region_locked : bp_area_hit;

  // reset sequencer; hardware resets outrank the software one
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      frhp_st_por:   if (!por_active) state_next = full_fire ? frhp_st_hwrst : frhp_st_run;
      frhp_st_run:   if (full_fire) state_next = frhp_st_hwrst;
                     else if (sw_fire) state_next = frhp_st_swrst;
      frhp_st_swrst: if (full_fire) state_next = frhp_st_hwrst;
                     else if (!sw_tif.busy) state_next = frhp_st_run;
      frhp_st_hwrst: if (!hw_rst_low) state_next = frhp_st_run;
    endcase
    if (por_active) state_next = frhp_st_por;
  end

  // timers: recovery after software reset, inhibit after power-up
  assign sw_tif.start = (state_next == frhp_st_swrst) & (state_reg != frhp_st_swrst);
  assign wi_tif.start = (state_reg == frhp_st_por) & ~por_active;

  frhp_delay_timer #(.CYCLES(SW_RESET_CYC)) u_sw_timer (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .tif   (sw_tif)
  );

  frhp_delay_timer #(.CYCLES(WR_INHIBIT_CYC)) u_wi_timer (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .tif   (wi_tif)
  );

  // reset pin low-time counter, saturating so hw_fire pulses once
  assign low_cnt_next = !hw_rst_low ? '0 :
                        (low_cnt_reg == RW'(RESET_MIN_CYC)) ? low_cnt_reg :
                        low_cnt_reg + RW'(1);

  // pin-only sequence: a clock edge or a wrong bit restarts it
  always_comb begin
    jseq_next = jseq_reg;
    if (sclk_edge || state_reg != frhp_st_run) jseq_next = 3'h0;
    else if (cs_rise) jseq_next = jedec_fire ? 3'h0 :
                                  jbit_ok ? jseq_reg + 3'h1 : {2'h0, ~si};
  end

  // selection arms only on a falling edge seen in the run state
  assign armed_next = (state_reg != frhp_st_run) ? 1'b0 : (armed_reg | cs_fall);

  // pause: hold-pin entry and exit only while the serial clock is low; deselect or leaving pause mode ends it at any clock level
  always_comb begin
    paused_next = paused_reg;
    if (!sel_now || !pause_fn) paused_next = 1'b0;
    else if (!paused_reg && !hold_rst_n && !sclk) paused_next = 1'b1;
    else if (paused_reg && hold_rst_n && !sclk) paused_next = 1'b0;
  end

  // output stays off until the first clock edge of the selection
  assign clk_seen_next = !sel_now ? 1'b0 :
                         (clk_seen_reg | (sclk_edge & ~paused_reg));

  // enable-reset is consumed by the very next accepted instruction
  assign en_rst_next = (state_reg != frhp_st_run) ? 1'b0 :
                       instr_ok ? (instr_code == `FRHP_OP_EN_RESET) : en_rst_reg;

  // write enable latch; set by write enable; reset paths, write disable, status write, program/erase and gated ext-address/region-protect writes clear it
  wire wel_clr = (state_reg != frhp_st_run) | por_active |
                 (instr_ok & (op_wrdi | op_wrsr | instr_is_prog_erase |
                  (instr_is_ext_addr_wr & ~four_byte_mode) |
                  (instr_is_region_prot & protect_scheme_select)));
  assign wel_next = (instr_ok & op_wren) ? 1'b1 : wel_clr ? 1'b0 : wel_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= frhp_st_por;
      cs_n_d_reg   <= 1'b1;
      sclk_d_reg   <= 1'b0;
      armed_reg    <= 1'b0;
      paused_reg   <= 1'b0;
      clk_seen_reg <= 1'b0;
      en_rst_reg   <= 1'b0;
      wel_reg      <= 1'b0;
      low_cnt_reg  <= '0;
      jseq_reg     <= 3'h0;
    end else begin
      state_reg    <= state_next;
      cs_n_d_reg   <= cs_n;
      sclk_d_reg   <= sclk;
      armed_reg    <= armed_next;
      paused_reg   <= paused_next;
      clk_seen_reg <= clk_seen_next;
      en_rst_reg   <= en_rst_next;
      wel_reg      <= wel_next;
      low_cnt_reg  <= low_cnt_next;
      jseq_reg     <= jseq_next;
    end
  end

  // registered outputs; no combinational path reaches a pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      selected_reg     <= 1'b0;
      standby_reg      <= 1'b1;
      so_oe_reg        <= 1'b0;
      iface_reset_reg  <= 1'b0;
      reset_busy_reg   <= 1'b1;
      instr_accept_reg <= 1'b0;
      status_ok_reg    <= 1'b0;
      array_ok_reg     <= 1'b0;
    end else begin
      selected_reg     <= sel_now;
      standby_reg      <= cs_n & ~write_in_progress;
      so_oe_reg        <= sel_now & ~paused_next & clk_seen_next & so_drive_req;
      iface_reset_reg  <= cs_rise & paused_reg;
      reset_busy_reg   <= (state_next != frhp_st_run);
      instr_accept_reg <= instr_ok;
      status_ok_reg    <= wel_next & ~sr_locked & ~inhibit;
      array_ok_reg     <= wel_next & ~area_locked & ~inhibit;
    end
  end

  assign selected           = selected_reg;
  assign standby            = standby_reg;
  assign paused             = paused_reg;
  assign so_oe              = so_oe_reg;
  assign iface_reset        = iface_reset_reg;
  assign reset_busy         = reset_busy_reg;
  assign write_inhibit      = inhibit;
  assign instr_accept       = instr_accept_reg;
  assign write_enable_latch = wel_reg;
  assign status_write_ok    = status_ok_reg;
  assign array_write_ok     = array_ok_reg;

  // checks beside the logic
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_hold_entry;
    pause_fn && sel_now && !paused_reg && !hold_rst_n && !sclk;
  endsequence
  sequence s_enable_then_reset;
    instr_ok && instr_code == `FRHP_OP_EN_RESET ##1 (!instr_ok)[*2]
      ##1 instr_ok && instr_code == `FRHP_OP_RESET && !full_fire && !por_active;
  endsequence

  AST_NO_SELECT_UNARMED: assert property ((!armed_reg && !cs_fall) |=> !selected_reg)
    else $error("selected without a prior chip-select fall");
  AST_POR_REFUSE: assert property (por_active |=> !instr_accept_reg && reset_busy_reg)
    else $error("instruction accepted under power-on reset");
  AST_STANDBY: assert property ((cs_n && !write_in_progress) |=> standby_reg)
    else $error("standby missing while deselected and idle");
  AST_PAUSE_MODE: assert property ((quad_io_enable || pause_or_reset_sel) |=> !paused_reg)
    else $error("pause active outside hold mode");
  AST_PAUSE_SO_OFF: assert property (paused_reg |-> !so_oe_reg)
    else $error("output driven during pause");
  AST_PAUSE_ENTRY: assert property (s_hold_entry |=> paused_reg)
    else $error("pause not entered on hold low with clock low");
  AST_CS_RISE_PAUSE: assert property ((paused_reg && cs_rise) |=> iface_reset_reg && !paused_reg)
    else $error("deselect during pause did not reset interface");
  AST_SW_RESET: assert property (s_enable_then_reset |=> state_reg == frhp_st_swrst)
    else $error("software reset sequence not taken");
  AST_SW_RECOVERY: assert property ((state_reg == frhp_st_swrst) |-> !instr_ok)
    else $error("instruction taken during reset recovery");
  AST_HW_RESET: assert property ((hw_rst_low && low_cnt_reg == RW'(RESET_MIN_CYC - 1))
    |=> state_reg == frhp_st_hwrst || state_reg == frhp_st_por)
    else $error("reset pin held long enough but no reset");
  AST_PIN_SEQ: assert property ((cs_rise && si && jseq_reg == 3'h3 && !sclk_edge && !por_active)
    |=> state_reg == frhp_st_hwrst)
    else $error("pin-only reset pattern ignored");
  AST_PIN_SEQ_ABORT: assert property (sclk_edge |=> jseq_reg == 3'h0)
    else $error("clock edge did not abandon pin-only reset");
  AST_SO_LATE: assert property (cs_fall |=> !so_oe_reg)
    else $error("output driven before first clock edge");
  AST_REGION_LOCK: assert property ((protect_scheme_select && region_locked) |=> !array_write_ok)
    else $error("array write allowed on locked region");
  AST_INHIBIT: assert property ((inhibit && instr_valid && wr_class) |-> !instr_ok)
    else $error("write-class instruction during inhibit delay");
  AST_WEL_CLEAR: assert property ((instr_ok && op_wrdi) |=> !write_enable_latch)
    else $error("write disable left latch set");
  AST_SR_LOCK: assert property ((status_lock_mode_lo && !status_lock_mode_hi && !wp_n)
    |=> !status_write_ok)
    else $error("status write allowed with protect pin low");
  AST_WEL_GATE: assert property (!wel_next |=> !status_write_ok && !array_write_ok)
    else $error("write allowed with latch clear");
endmodule
`default_nettype wire

//--- frhp_host_model.sv
// host controller model driving the serial pins of the flash control
`timescale 1ns/10ps
`default_nettype none
module frhp_host_model (
  // clock
  input  wire logic ref_clk,
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  output logic      hold_rst_n
);
  // chip select starts low on purpose: a low level alone must not select
  initial begin
    cs_n = 1'h0;
    sclk = 1'h0;
    si = 1'h0;
    hold_rst_n = 1'h1;
  end
  // chip select level, moved just after a falling clock edge
  task automatic sel(input logic on);
    @(negedge ref_clk);
    cs_n = ~on;
  endtask
  // one serial clock transition outside any reset frame
  task automatic tick;
    @(negedge ref_clk);
    sclk = ~sclk;
  endtask
  // pause pin moves only while the serial clock is low
  task automatic hold(input logic lvl);
    @(negedge ref_clk);
    sclk = 1'h0;
    hold_rst_n = lvl;
  endtask
  // one pin-only reset frame; tog adds a clock edge that spoils the sequence
  task automatic frame(input logic b, input logic tog);
    @(negedge ref_clk);
    cs_n = 1'h0;
    si = b;
    repeat (3) @(negedge ref_clk);
    if (tog)
      sclk = ~sclk;
    repeat (3) @(negedge ref_clk);
    cs_n = 1'h1;
    repeat (3) @(negedge ref_clk);
    si = ~b; // hold time over, so the old level must not linger
  endtask
endmodule
`default_nettype wire

//--- frhp_ctrl_tb_top.sv
// self-checking bench of the flash reset, pause and protect control
`timescale 1ns/10ps
`default_nettype none
module frhp_ctrl_tb_top;
  localparam int RMC = 8;
  localparam int SWC = 20;
  // design pins and bench state
  logic ref_clk, resetn, por_active, cs_n, sclk, si, hold_rst_n, dedicated_rst_n, wp_n;
  logic quad_io_enable, pause_or_reset_sel, protect_scheme_select, status_lock_mode_hi;
  logic status_lock_mode_lo, instr_valid, instr_is_prog_erase, write_in_progress;
  logic deep_power_down, so_drive_req, bp_area_hit, persistent_region_lock;
  logic [7:0] instr_code;
  logic four_byte_mode, instr_is_ext_addr_wr, instr_is_region_prot, volatile_region_lock;
  logic selected, standby, paused, so_oe, iface_reset, reset_busy, write_inhibit;
  logic instr_accept, write_enable_latch, status_write_ok, array_write_ok;
  logic busy_seen, ir_seen, acc;
  int   error_cnt, n_compared;

  frhp_ctrl #(.RESET_MIN_CYC(RMC), .SW_RESET_CYC(SWC), .WR_INHIBIT_CYC(30)) frhp_ctrl_inst (
    .ref_clk(ref_clk), .resetn(resetn), .por_active(por_active), .cs_n(cs_n), .sclk(sclk),
    .si(si), .hold_rst_n(hold_rst_n), .dedicated_rst_n(dedicated_rst_n), .wp_n(wp_n),
    .quad_io_enable(quad_io_enable), .pause_or_reset_sel(pause_or_reset_sel),
    .protect_scheme_select(protect_scheme_select), .status_lock_mode_hi(status_lock_mode_hi),
    .status_lock_mode_lo(status_lock_mode_lo), .four_byte_mode(four_byte_mode),
    .instr_valid(instr_valid), .instr_code(instr_code),
    .instr_is_prog_erase(instr_is_prog_erase), .instr_is_ext_addr_wr(instr_is_ext_addr_wr),
    .instr_is_region_prot(instr_is_region_prot), .write_in_progress(write_in_progress),
    .deep_power_down(deep_power_down), .so_drive_req(so_drive_req), .bp_area_hit(bp_area_hit),
    .persistent_region_lock(persistent_region_lock),
    .volatile_region_lock(volatile_region_lock),
    .selected(selected), .standby(standby), .paused(paused), .so_oe(so_oe),
    .iface_reset(iface_reset), .reset_busy(reset_busy), .write_inhibit(write_inhibit),
    .instr_accept(instr_accept), .write_enable_latch(write_enable_latch),
    .status_write_ok(status_write_ok), .array_write_ok(array_write_ok));
  frhp_host_model frhp_host_model_inst (
    .ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .hold_rst_n(hold_rst_n));

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // one-cycle pulses are caught here so checks may come later
  always @(negedge ref_clk) begin
    if (reset_busy === 1'h1)
      busy_seen = 1'h1;
    if (iface_reset === 1'h1)
      ir_seen = 1'h1;
  end

  task automatic chk(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic close_out;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask
  // one decoded instruction; acc tells whether it was taken
  // f holds the region-protect, extended-address and program/erase flags
  task automatic ins(input logic [7:0] c, input logic [2:0] f);
    @(negedge ref_clk);
    instr_valid = 1'h1;
    instr_code = c;
    {instr_is_region_prot, instr_is_ext_addr_wr, instr_is_prog_erase} = f;
    @(negedge ref_clk);
    instr_valid = 1'h0;
    {instr_is_region_prot, instr_is_ext_addr_wr, instr_is_prog_erase} = 3'h0;
    acc = instr_accept;
    @(negedge ref_clk);
    acc = acc | instr_accept;
  endtask
  task automatic try(input logic [7:0] c, input logic e);
    ins(c, 3'h0);
    chk("instr_accept", e, acc);
  endtask
  // bounded wait for recovery and inhibit to end
  task automatic wait_idle;
    for (int i = 0; i < 500; i++) begin
      @(negedge ref_clk);
      if (reset_busy === 1'h0 && write_inhibit === 1'h0)
        return;
    end
    chk("idle wait", 1'h1, 1'h0);
    close_out;
  endtask
  // a fresh chip-select fall is needed after every reset
  task automatic arm;
    frhp_host_model_inst.sel(1'h0);
    frhp_host_model_inst.sel(1'h1);
    @(negedge ref_clk);
  endtask

  task automatic t_power_up;
    repeat (5) @(negedge ref_clk);
    chk("standby", 1'h1, standby);
    chk("reset_busy", 1'h1, reset_busy);
    resetn = 1'h1;
    repeat (8) @(negedge ref_clk);
    chk("reset_busy", 1'h1, reset_busy);
    try(8'h04, 1'h0);
    por_active = 1'h0;
    repeat (3) @(negedge ref_clk);
    chk("write_inhibit", 1'h1, write_inhibit);
    try(8'h04, 1'h0);
    chk("selected", 1'h0, selected);
    arm;
    try(8'h06, 1'h0);
    try(8'h04, 1'h1);
    wait_idle;
    try(8'h06, 1'h1);
    chk("wel", 1'h1, write_enable_latch);
    frhp_host_model_inst.sel(1'h0);
    settle;
    chk("standby", 1'h1, standby);
    write_in_progress = 1'h1;
    settle;
    chk("standby", 1'h0, standby);
    write_in_progress = 1'h0;
    frhp_host_model_inst.sel(1'h1);
    settle;
    chk("selected", 1'h1, selected);
    chk("so_oe", 1'h0, so_oe);
  endtask
  task automatic t_sw_reset;
    int n;
    busy_seen = 1'h0;
    try(8'h66, 1'h1);
    try(8'h06, 1'h1);
    try(8'h99, 1'h1);
    chk("reset after broken pair", 1'h0, busy_seen);
    try(8'h66, 1'h1);
    try(8'h99, 1'h1);
    try(8'h04, 1'h0);
    chk("wel", 1'h0, write_enable_latch);
    n = 0;
    while (reset_busy === 1'h1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk("recovery length", 1'h1, n >= SWC - 8 && n <= SWC);
    if (n >= 100)
      close_out;
    wait_idle;
    arm;
  endtask
  task automatic t_pause;
    frhp_host_model_inst.tick;
    settle;
    chk("so_oe", 1'h1, so_oe);
    frhp_host_model_inst.hold(1'h0);
    settle;
    chk("paused", 1'h1, paused);
    chk("so_oe", 1'h0, so_oe);
    try(8'h04, 1'h0);
    frhp_host_model_inst.hold(1'h1);
    settle;
    chk("paused", 1'h0, paused);
    quad_io_enable = 1'h1;
    frhp_host_model_inst.hold(1'h0);
    settle;
    chk("paused", 1'h0, paused);
    frhp_host_model_inst.hold(1'h1);
    quad_io_enable = 1'h0;
    frhp_host_model_inst.hold(1'h0);
    settle;
    ir_seen = 1'h0;
    frhp_host_model_inst.sel(1'h0);
    settle;
    chk("iface_reset", 1'h1, ir_seen);
    chk("paused", 1'h0, paused);
    frhp_host_model_inst.hold(1'h1);
    arm;
  endtask
  task automatic t_pin_reset;
    try(8'h06, 1'h1);
    pause_or_reset_sel = 1'h1;
    busy_seen = 1'h0;
    frhp_host_model_inst.hold(1'h0);
    repeat (RMC - 6) @(negedge ref_clk);
    chk("paused", 1'h0, paused);
    try(8'h04, 1'h0);
    frhp_host_model_inst.hold(1'h1);
    settle;
    chk("reset on short pulse", 1'h0, busy_seen);
    chk("wel", 1'h1, write_enable_latch);
    frhp_host_model_inst.hold(1'h0);
    repeat (RMC + 2) @(negedge ref_clk);
    frhp_host_model_inst.hold(1'h1);
    settle;
    chk("reset on long pulse", 1'h1, busy_seen);
    chk("wel", 1'h0, write_enable_latch);
    quad_io_enable = 1'h1;
    busy_seen = 1'h0;
    frhp_host_model_inst.hold(1'h0);
    repeat (RMC + 2) @(negedge ref_clk);
    frhp_host_model_inst.hold(1'h1);
    settle;
    chk("reset with quad on", 1'h0, busy_seen);
    dedicated_rst_n = 1'h0;
    repeat (RMC + 2) @(negedge ref_clk);
    dedicated_rst_n = 1'h1;
    settle;
    chk("dedicated reset", 1'h1, busy_seen);
    quad_io_enable = 1'h0;
    pause_or_reset_sel = 1'h0;
    wait_idle;
  endtask
  task automatic t_seq_reset;
    frhp_host_model_inst.sel(1'h0);
    busy_seen = 1'h0;
    frhp_host_model_inst.frame(1'h0, 1'h0);
    frhp_host_model_inst.frame(1'h1, 1'h1);
    frhp_host_model_inst.frame(1'h0, 1'h0);
    frhp_host_model_inst.frame(1'h1, 1'h0);
    chk("reset after clock edge", 1'h0, busy_seen);
    frhp_host_model_inst.frame(1'h1, 1'h0);
    for (int k = 0; k < 4; k++)
      frhp_host_model_inst.frame(k[0], 1'h0);
    chk("reset after 0101", 1'h1, busy_seen);
    wait_idle;
    arm;
  endtask
  task automatic t_protect;
    try(8'h06, 1'h1);
    wp_n = 1'h0;
    status_lock_mode_lo = 1'h1;
    settle;
    chk("status_write_ok", 1'h0, status_write_ok);
    wp_n = 1'h1;
    bp_area_hit = 1'h1;
    persistent_region_lock = 1'h1;
    settle;
    chk("status_write_ok", 1'h1, status_write_ok);
    chk("array_write_ok", 1'h0, array_write_ok);
    protect_scheme_select = 1'h1;
    settle;
    chk("array_write_ok", 1'h0, array_write_ok);
    persistent_region_lock = 1'h0;
    settle;
    chk("array_write_ok", 1'h1, array_write_ok);
    ins(8'h01, 3'h0);
    settle;
    chk("wel", 1'h0, write_enable_latch);
    chk("status_write_ok", 1'h0, status_write_ok);
    try(8'h06, 1'h1);
    ins(8'h02, 3'h1);
    settle;
    chk("wel", 1'h0, write_enable_latch);
    try(8'h06, 1'h1);
    volatile_region_lock = 1'h1;
    settle;
    chk("array_write_ok", 1'h0, array_write_ok);
    status_lock_mode_hi = 1'h1;
    settle;
    chk("status_write_ok", 1'h0, status_write_ok);
    four_byte_mode = 1'h1;
    ins(8'hC5, 3'h2);
    chk("wel", 1'h1, write_enable_latch);
    four_byte_mode = 1'h0;
    ins(8'hC5, 3'h2);
    chk("wel", 1'h0, write_enable_latch);
    try(8'h06, 1'h1);
    ins(8'hE1, 3'h4);
    chk("wel", 1'h0, write_enable_latch);
  endtask
  task automatic t_misc;
    deep_power_down = 1'h1;
    so_drive_req = 1'h0;
    try(8'h06, 1'h0);
    try(8'hAB, 1'h1);
    deep_power_down = 1'h0;
    por_active = 1'h1;
    settle;
    chk("reset_busy", 1'h1, reset_busy);
    try(8'h04, 1'h0);
  endtask

  initial begin
    {resetn, instr_valid, instr_is_prog_erase, write_in_progress, deep_power_down} = '0;
    {quad_io_enable, pause_or_reset_sel, protect_scheme_select, status_lock_mode_hi} = '0;
    {status_lock_mode_lo, bp_area_hit, persistent_region_lock, busy_seen, ir_seen} = '0;
    {por_active, dedicated_rst_n, wp_n, so_drive_req} = '1;
    instr_code = 8'h00;
    {four_byte_mode, instr_is_ext_addr_wr, instr_is_region_prot, volatile_region_lock} = '0;
    error_cnt = 0;
    n_compared = 0;
    t_power_up;
    t_sw_reset;
    t_pause;
    t_pin_reset;
    t_seq_reset;
    t_protect;
    t_misc;
    close_out;
  end
endmodule
`default_nettype wire
